// [common/spc_pkg.sv]
package spc_pkg;

    localparam int DATA_W = 8;
    localparam int NUM_CS = 4;
    localparam int CS_IDX_W = 2;
    localparam int DIV_W = 8;
    localparam int EDGE_W = 4;
    localparam int BIT_W = 3;

    // sixteen sck edges carry one character
    localparam logic [EDGE_W-1:0] LAST_EDGE = 4'hf;
    localparam logic [BIT_W-1:0] LAST_BIT = 3'h7;
    localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;

    // reset values
    localparam logic TX_EMPTY_RST = 1'b1;
    localparam logic RX_READY_RST = 1'b0;
    localparam logic ENABLE_RST = 1'b0;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    // per chip select configuration
    typedef struct packed {
        logic [DIV_W-1:0] baud_divider;
        logic clock_polarity;
        logic clock_phase;            // 1: capture on leading edge
        logic cs_hold_after_transfer;
    } spc_cs_cfg_s;

    // mode register fields
    typedef struct packed {
        logic master;
        logic mode_fault_disable;
        logic [CS_IDX_W-1:0] cs_index;
    } spc_mode_s;

    typedef enum logic [1:0] {
        SPC_IDLE = 2'b00,
        SPC_GLITCH = 2'b01,
        SPC_RUN = 2'b10
    } spc_state_e;

endpackage

// [verilog/spc_baud_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_baud_gen (
    input wire logic CLK_I,                   // system clock
    input wire logic RST_N_I,                 // sync reset, active low
    input wire logic restart_i,               // hold counter at zero
    input wire logic [spc_pkg::DIV_W-1:0] div_i, // half period in cycles
    output logic tick_o                       // one-cycle half-period pulse
);
    import spc_pkg::*;

    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] limit;

    // a divider of zero would stall sck, so it acts as one
    assign limit = (div_i == '0) ? '0 : div_i - DIV_ONE;

    // free count between restarts, pulse on wrap
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || restart_i) begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else if (cnt_reg >= limit) begin
            cnt_reg <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + DIV_ONE;
            tick_o <= 1'b0;
        end
    end
endmodule // spc_baud_gen
`default_nettype wire

// [verilog/spc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_ctrl #(
    parameter int NCS = spc_pkg::NUM_CS       // number of chip selects
) (
    input wire logic CLK_I,                   // 100 MHz system clock
    input wire logic RST_N_I,                 // sync reset, active low
    input wire logic SW_RESET_I,              // software reset pulse
    input wire logic ENABLE_I,                // enable command pulse
    input wire logic DISABLE_I,               // disable command pulse
    input wire spc_pkg::spc_mode_s MODE_I,    // mode register
    input wire spc_pkg::spc_cs_cfg_s [NCS-1:0] CS_CFG_I, // per cs config
    input wire logic TX_WRITE_I,              // tx data write strobe
    input wire logic [spc_pkg::DATA_W-1:0] TX_DATA_I, // tx data
    input wire logic RX_READ_I,               // rx holding read strobe
    input wire logic MF_CLEAR_I,              // clear mode fault flag
    output logic [spc_pkg::DATA_W-1:0] RX_DATA_O, // rx holding register
    output logic TX_EMPTY_O,                  // tx empty flag
    output logic RX_READY_O,                  // rx ready flag
    output logic DMA_TX_REQ_O,                // dma channel request
    output logic MODE_FAULT_O,                // mode fault flag
    output logic ENABLED_O,                   // controller enabled
    input wire logic SCK_I,                   // sck pin in
    output logic SCK_O,                       // sck pin out
    output logic SCK_OE_O,                    // sck drive enable
    input wire logic MOSI_I,                  // mosi pin in
    output logic MOSI_O,                      // mosi pin out
    output logic MOSI_OE_O,                   // mosi drive enable
    input wire logic MISO_I,                  // miso pin in
    output logic MISO_O,                      // miso pin out
    output logic MISO_OE_O,                   // miso drive enable
    input wire logic NSS_I,                   // slave select / fault in
    output logic [NCS-1:0] CS_N_O             // chip selects, active low
);
    import spc_pkg::*;

    spc_state_e state_reg;
    logic [3:0] sync1_reg, sync2_reg, sync3_reg;
    logic en_reg, en_prev_reg, mf_reg;
    logic tx_empty_reg, rx_ready_reg;
    logic [DATA_W-1:0] tx_data_reg, rx_hold_reg, tx_shift_reg, rx_shift_reg;
    logic [EDGE_W-1:0] edge_cnt_reg;
    logic [BIT_W-1:0] bit_cnt_reg;
    logic [CS_IDX_W-1:0] cur_cs_reg, last_cs_reg;
    logic sck_reg, sck_oe_reg, mosi_oe_reg, miso_oe_reg;
    logic [NCS-1:0] cs_n_reg;
    logic srst, tick, nss_s, sck_s, mosi_s, miso_s;
    logic [CS_IDX_W-1:0] idx;
    spc_cs_cfg_s cfg;
    logic master_on, slave_on, start, glitch, block_start, mf_evt;
    logic edge_fire, lead, samp, shft, done_evt, load_evt, nss_fall;
    logic tx_accept, rx_bit;

    function automatic logic div_is_one(input logic [DIV_W-1:0] d);
        return d == DIV_ONE;
    endfunction

    function automatic logic [NCS-1:0] cs_onehot(input logic [CS_IDX_W-1:0] i);
        logic [NCS-1:0] v;
        v = '0;
        v[i] = 1'b1;
        return v;
    endfunction

    assign srst = !RST_N_I || SW_RESET_I;

    // pins cross into the clock domain; stage one feeds stage two only
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            sync1_reg <= 4'hf;
            sync2_reg <= 4'hf;
            sync3_reg <= 4'hf;
        end else begin
            sync1_reg <= {NSS_I, SCK_I, MOSI_I, MISO_I};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end
    assign {nss_s, sck_s, mosi_s, miso_s} = sync2_reg;

    // configuration of the chip select in use
    assign idx = (state_reg == SPC_IDLE) ? MODE_I.cs_index : cur_cs_reg;
    assign cfg = CS_CFG_I[idx];
    assign master_on = en_reg && MODE_I.master;
    assign slave_on = en_reg && !MODE_I.master;
    assign mf_evt = master_on && !MODE_I.mode_fault_disable && !nss_s;

    // holding cs0 needs nss kept high, which the fault check never sees
    assign block_start = CS_CFG_I[0].cs_hold_after_transfer &&
                         !MODE_I.mode_fault_disable;
    assign start = master_on && !tx_empty_reg && !block_start &&
                   !mf_evt && (state_reg == SPC_IDLE);
    // switching between a divide-by-one cs and another one misfires when the new cs has polarity 1 and phase 0
    assign glitch = (MODE_I.cs_index != last_cs_reg) &&
                    (div_is_one(CS_CFG_I[last_cs_reg].baud_divider) !=
                     div_is_one(cfg.baud_divider)) &&
                    cfg.clock_polarity && !cfg.clock_phase;

    // edge decode shared by master and slave
    assign nss_fall = slave_on && sync3_reg[3] && !nss_s;
    assign edge_fire = MODE_I.master ? (state_reg == SPC_RUN && tick) :
                       (slave_on && !nss_s && (sck_s != sync3_reg[2]));
    assign lead = MODE_I.master ? !edge_cnt_reg[0] :
                  (sck_s != cfg.clock_polarity);
    assign samp = edge_fire && (lead == cfg.clock_phase);
    assign shft = edge_fire && (lead != cfg.clock_phase) &&
                  (edge_cnt_reg != '0);
    assign done_evt = samp && (bit_cnt_reg == LAST_BIT);
    assign rx_bit = MODE_I.master ? miso_s : mosi_s;
    // an empty holding register at a slave byte boundary leaves the
    // old shifter contents going out, and nothing flags it
    assign load_evt = start ||
                      ((nss_fall || (slave_on && done_evt)) &&
                       !tx_empty_reg);
    assign tx_accept = TX_WRITE_I && en_reg;

    spc_baud_gen u_baud (
        .CLK_I(CLK_I),
        .RST_N_I(RST_N_I),
        .restart_i(state_reg == SPC_IDLE),
        .div_i(cfg.baud_divider),
        .tick_o(tick)
    );

    // enable state; slave mode ignores the disable command
    always_ff @(posedge CLK_I) begin
        if (srst) begin
            en_reg <= ENABLE_RST;
            en_prev_reg <= ENABLE_RST;
        end else begin
            en_prev_reg <= en_reg;
            if (mf_evt) begin
                en_reg <= 1'b0;
            end else if (DISABLE_I && MODE_I.master) begin
                en_reg <= 1'b0;
            end else if (ENABLE_I) begin
                en_reg <= 1'b1;
            end
        end
    end

    // mode fault flag, a new fault beats the clear
    always_ff @(posedge CLK_I) begin
        if (srst) begin
            mf_reg <= 1'b0;
        end else if (mf_evt) begin
            mf_reg <= 1'b1;
        end else if (MF_CLEAR_I) begin
            mf_reg <= 1'b0;
        end
    end

    // tx holding register; the flag is not touched by disable, so the
    // dma keeps writing into a register that drops every word
    always_ff @(posedge CLK_I) begin
        if (srst) begin
            tx_empty_reg <= TX_EMPTY_RST;
            tx_data_reg <= DATA_RST;
        end else if (tx_accept) begin
            tx_data_reg <= TX_DATA_I;
            tx_empty_reg <= 1'b0;
        end else if (load_evt) begin
            tx_empty_reg <= 1'b1;
        end
    end

    // rx holding register; enabling a slave raises a spurious ready
    always_ff @(posedge CLK_I) begin
        if (srst) begin
            rx_ready_reg <= RX_READY_RST;
            rx_hold_reg <= DATA_RST;
        end else if (done_evt) begin
            rx_hold_reg <= {rx_shift_reg[DATA_W-2:0], rx_bit};
            rx_ready_reg <= 1'b1;
        end else if (slave_on && !en_prev_reg) begin
            rx_ready_reg <= 1'b1;
        end else if (RX_READ_I) begin
            rx_ready_reg <= 1'b0;
        end
    end

    // shifter, counters, sck and chip selects
    always_ff @(posedge CLK_I) begin
        if (srst) begin
            state_reg <= SPC_IDLE;
            sck_reg <= 1'b0;
            edge_cnt_reg <= '0;
            bit_cnt_reg <= '0;
            tx_shift_reg <= DATA_RST;
            rx_shift_reg <= DATA_RST;
            cur_cs_reg <= '0;
            last_cs_reg <= '0;
            cs_n_reg <= '1;
        end else begin
            if (samp) begin
                rx_shift_reg <= {rx_shift_reg[DATA_W-2:0], rx_bit};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
            if (load_evt) begin
                tx_shift_reg <= tx_data_reg;
            end else if (shft) begin
                tx_shift_reg <= {tx_shift_reg[DATA_W-2:0], 1'b0};
            end
            if (edge_fire) begin
                edge_cnt_reg <= edge_cnt_reg + 4'h1;
            end
            if (!MODE_I.master) begin
                sck_reg <= cfg.clock_polarity;
                state_reg <= SPC_IDLE;
                cs_n_reg <= '1;
                if (nss_s || !en_reg || done_evt) begin
                    edge_cnt_reg <= '0;
                end
                if (nss_s || !en_reg) begin
                    bit_cnt_reg <= '0;
                end
            end else if (!en_reg || mf_evt) begin
                state_reg <= SPC_IDLE;
                sck_reg <= cfg.clock_polarity;
                cs_n_reg <= '1;
            end else begin
                unique case (state_reg)
                    SPC_IDLE: begin
                        sck_reg <= cfg.clock_polarity;
                        edge_cnt_reg <= '0;
                        bit_cnt_reg <= '0;
                        if (start) begin
                            cur_cs_reg <= MODE_I.cs_index;
                            last_cs_reg <= MODE_I.cs_index;
                            cs_n_reg <= ~cs_onehot(MODE_I.cs_index);
                            if (glitch) begin
                                sck_reg <= !cfg.clock_polarity;
                                state_reg <= SPC_GLITCH;
                            end else begin
                                state_reg <= SPC_RUN;
                            end
                        end
                    end
                    SPC_GLITCH: begin
                        if (tick) begin
                            sck_reg <= cfg.clock_polarity;
                            state_reg <= SPC_RUN;
                        end
                    end
                    SPC_RUN: begin
                        if (tick) begin
                            sck_reg <= !sck_reg;
                        end
                        if (tick && edge_cnt_reg == LAST_EDGE) begin
                            state_reg <= SPC_IDLE;
                            if (!cfg.cs_hold_after_transfer) begin
                                cs_n_reg <= '1;
                            end
                        end
                    end
                    default: begin
                        state_reg <= SPC_IDLE;
                    end
                endcase
            end
        end
    end

    // drive enables follow the role, registered with the pins
    always_ff @(posedge CLK_I) begin
        if (srst) begin
            sck_oe_reg <= 1'b0;
            mosi_oe_reg <= 1'b0;
            miso_oe_reg <= 1'b0;
        end else begin
            sck_oe_reg <= master_on;
            mosi_oe_reg <= master_on;
            miso_oe_reg <= slave_on && !nss_s;
        end
    end

    assign RX_DATA_O = rx_hold_reg;
    assign TX_EMPTY_O = tx_empty_reg;
    assign RX_READY_O = rx_ready_reg;
    assign DMA_TX_REQ_O = tx_empty_reg;
    assign MODE_FAULT_O = mf_reg;
    assign ENABLED_O = en_reg;
    assign SCK_O = sck_reg;
    assign SCK_OE_O = sck_oe_reg;
    assign MOSI_O = tx_shift_reg[DATA_W-1];
    assign MOSI_OE_O = mosi_oe_reg;
    assign MISO_O = tx_shift_reg[DATA_W-1];
    assign MISO_OE_O = miso_oe_reg;
    assign CS_N_O = cs_n_reg;
endmodule // spc_ctrl
`default_nettype wire

// [sim/spc_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_sva #(
    parameter int NCS = spc_pkg::NUM_CS           // chip selects
) (
    input wire logic CLK_I,                       // clock
    input wire logic RST_N_I,                     // reset, low
    input wire logic SW_RESET_I,                  // soft reset
    input wire logic DISABLE_I,                   // disable pulse
    input wire spc_pkg::spc_mode_s MODE_I,        // mode
    input wire spc_pkg::spc_cs_cfg_s [NCS-1:0] CS_CFG_I, // cs config
    input wire logic TX_WRITE_I,                  // tx write
    input wire logic TX_EMPTY_O,                  // tx empty
    input wire logic RX_READY_O,                  // rx ready
    input wire logic DMA_TX_REQ_O,                // dma request
    input wire logic MODE_FAULT_O,                // mode fault
    input wire logic ENABLED_O,                   // enabled
    input wire logic [NCS-1:0] CS_N_O             // chip selects
);
    import spc_pkg::*;
    // one domain; a soft reset voids the checks like the pin reset
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I || SW_RESET_I);
    sequence s_write; TX_WRITE_I && ENABLED_O; endsequence
    sequence s_slave_up; $rose(ENABLED_O) && !MODE_I.master; endsequence
    property p_write; s_write |=> !TX_EMPTY_O; endproperty
    a_write: assert property (p_write) else $error("write kept empty");
    property p_off; !ENABLED_O |=> $stable(TX_EMPTY_O); endproperty
    a_off: assert property (p_off) else $error("flag moved when off");
    property p_dma; DMA_TX_REQ_O == TX_EMPTY_O; endproperty
    a_dma: assert property (p_dma) else $error("dma request differs");
    property p_dma_off; !ENABLED_O && DMA_TX_REQ_O |=> DMA_TX_REQ_O;
    endproperty
    a_dma_off: assert property (p_dma_off) else $error("request lost");
    property p_hold; (&CS_N_O) && CS_CFG_I[0].cs_hold_after_transfer
        && !MODE_I.mode_fault_disable |=> &CS_N_O; endproperty
    a_hold: assert property (p_hold) else $error("transfer started");
    property p_slv; ENABLED_O && !MODE_I.master && DISABLE_I |=> ENABLED_O;
    endproperty
    a_slv: assert property (p_slv) else $error("slave was stopped");
    property p_load; $fell(CS_N_O[0]) && !$past(TX_WRITE_I) |-> TX_EMPTY_O;
    endproperty
    a_load: assert property (p_load) else $error("empty not set");
    property p_glitch; s_slave_up |-> ##[0:2] RX_READY_O; endproperty
    a_glitch: assert property (p_glitch) else $error("no ready at start");
    property p_fault; $rose(MODE_FAULT_O) |-> !ENABLED_O && &CS_N_O;
    endproperty
    a_fault: assert property (p_fault) else $error("fault left it on");
endmodule // spc_sva
bind spc_ctrl spc_sva #(.NCS(NCS)) u_sva (.CLK_I, .RST_N_I, .SW_RESET_I,
    .DISABLE_I, .MODE_I, .CS_CFG_I, .TX_WRITE_I, .TX_EMPTY_O, .RX_READY_O,
    .DMA_TX_REQ_O, .MODE_FAULT_O, .ENABLED_O, .CS_N_O);
`default_nettype wire

// [sim/spc_far_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_far_slave (
    input wire logic sck_i,          // serial clock
    input wire logic cs_n_i,         // select, low
    input wire logic mosi_i,         // data in
    input wire logic [7:0] reply_i,  // byte sent back
    input wire integer lag_i,        // output delay, ns
    output logic miso_o,             // data out
    output logic [7:0] rx_o          // bits taken
);
    logic [7:0] sh;
    initial begin
        miso_o = 1'b0;
        rx_o = 8'h00;
        sh = 8'h00;
    end
    // first bit must sit on the line before the first edge
    always @(negedge cs_n_i) begin
        sh = reply_i;
        miso_o = reply_i[7];
    end
    always @(posedge sck_i) if (!cs_n_i) rx_o = {rx_o[6:0], mosi_i};
    // a slow part moves its output late, not on the edge
    always @(negedge sck_i) if (!cs_n_i) begin
        sh = {sh[6:0], 1'b0};
        #(lag_i) miso_o = sh[7];
    end
    // released line: never leave the last bit standing
    always @(posedge cs_n_i) miso_o = ~miso_o;
endmodule // spc_far_slave
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    n_fail++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench;
    import spc_pkg::*;
    localparam int EN = 0, DIS = 1, RD = 2, CLR = 3, SWR = 4;
    localparam logic [7:0] SLV = 8'hb4;
    int n_fail = 0;
    int samples_checked = 0;
    int falls = 0;
    int far_lag = 0;
    logic [7:0] miso_got = 8'h00;
    logic CLK_I = 0, RST_N_I = 0, SW_RESET_I = 0, ENABLE_I = 0;
    logic DISABLE_I = 0, TX_WRITE_I = 0, RX_READ_I = 0, MF_CLEAR_I = 0;
    logic SCK_I = 0, MOSI_I = 0, NSS_I = 1, sck_q = 0;
    logic [7:0] TX_DATA_I = 8'h00, far_reply = 8'hc5, far_rx, RX_DATA_O;
    spc_mode_s MODE_I = '0;
    spc_cs_cfg_s [NUM_CS-1:0] CS_CFG_I = '0;
    logic TX_EMPTY_O, RX_READY_O, DMA_TX_REQ_O, MODE_FAULT_O, ENABLED_O;
    logic SCK_O, SCK_OE_O, MOSI_O, MOSI_OE_O, MISO_O, MISO_OE_O, miso_far;
    logic [NUM_CS-1:0] CS_N_O;
    // pin levels follow whoever enables its driver
    wire sck_w = SCK_OE_O ? SCK_O : SCK_I;
    wire mosi_w = MOSI_OE_O ? MOSI_O : MOSI_I;
    wire miso_w = MISO_OE_O ? MISO_O : miso_far;
    spc_ctrl #(.NCS(NUM_CS)) dut (.CLK_I, .RST_N_I, .SW_RESET_I, .ENABLE_I,
        .DISABLE_I, .MODE_I, .CS_CFG_I, .TX_WRITE_I, .TX_DATA_I, .RX_READ_I,
        .MF_CLEAR_I, .RX_DATA_O, .TX_EMPTY_O, .RX_READY_O, .DMA_TX_REQ_O,
        .MODE_FAULT_O, .ENABLED_O, .SCK_I(sck_w), .SCK_O, .SCK_OE_O,
        .MOSI_I(mosi_w), .MOSI_O, .MOSI_OE_O, .MISO_I(miso_w), .MISO_O,
        .MISO_OE_O, .NSS_I, .CS_N_O);
    spc_far_slave far (.sck_i(sck_w), .cs_n_i(CS_N_O[0]), .mosi_i(mosi_w),
        .reply_i(far_reply), .lag_i(far_lag), .miso_o(miso_far), .rx_o(far_rx));
    initial begin
        forever #5 CLK_I = ~CLK_I;
    end
    // sck falls under chip select 1 reveal a stray pulse
    always @(posedge CLK_I) begin
        sck_q <= SCK_O;
        if (sck_q && !SCK_O && !CS_N_O[1]) falls <= falls + 1;
    end
    task final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ends just after an edge so outputs have settled
    task cyc(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask
    task cmd(input int k);
        @(posedge CLK_I);
        case (k)
            EN: ENABLE_I <= 1'b1;
            DIS: DISABLE_I <= 1'b1;
            RD: RX_READ_I <= 1'b1;
            CLR: MF_CLEAR_I <= 1'b1;
            default: SW_RESET_I <= 1'b1;
        endcase
        @(posedge CLK_I);
        {ENABLE_I, DISABLE_I, RX_READ_I, MF_CLEAR_I, SW_RESET_I} <= 5'h00;
        #1;
    endtask
    task put(input logic [7:0] d, input logic exp_empty);
        @(posedge CLK_I);
        TX_WRITE_I <= 1'b1;
        TX_DATA_I <= d;
        @(posedge CLK_I);
        TX_WRITE_I <= 1'b0;
        #1;
        `CHK("tx_empty", exp_empty, TX_EMPTY_O)
    endtask
    // what 0: rx ready, 1: all selects idle; bounded
    task wait_for(input int what);
        int i;
        i = 0;
        while (i < 3000 && (what ? (&CS_N_O) !== 1'b1 : RX_READY_O !== 1'b1))
        begin
            cyc(1);
            i++;
        end
        if (i == 3000) begin
            n_fail++;
            $display("[ERR] wait %0d exp done got timeout", what);
            final_report();
        end
    endtask
    task xfer(input logic [1:0] cs, input logic [7:0] d);
        MODE_I.cs_index <= cs;
        put(d, 1'b0);
        wait_for(0);
        cmd(RD);
    endtask
    initial begin
        cyc(16);
        `CHK("reset", {5'h10, 4'hf, 8'h00}, {TX_EMPTY_O, RX_READY_O,
            ENABLED_O, MODE_FAULT_O, SCK_OE_O, CS_N_O, RX_DATA_O})
        RST_N_I <= 1'b1;
        put(8'ha5, 1'b1);
        `CHK("dma_req", 1'b1, DMA_TX_REQ_O)
        $display("done reset and write while off");
        MODE_I <= '{1'b1, 1'b1, 2'h0};
        for (int k = 0; k < NUM_CS; k++) CS_CFG_I[k] <= '{8'h04, 0, 1, 0};
        cmd(EN);
        xfer(2'h0, 8'h3c);
        // last sck edge still pending; new config must not meet it
        wait_for(1);
        `CHK("rx_data", 8'hc5, RX_DATA_O)
        `CHK("far_rx", 8'h3c, far_rx)
        `CHK("tx_empty", 1'b1, TX_EMPTY_O)
        $display("done master transfer");
        CS_CFG_I[0].cs_hold_after_transfer <= 1'b1;
        MODE_I.mode_fault_disable <= 1'b0;
        put(8'h5a, 1'b0);
        cyc(100);
        `CHK("no_start", 5'h0f, {TX_EMPTY_O, CS_N_O})
        MODE_I.mode_fault_disable <= 1'b1;
        wait_for(0);
        cmd(RD);
        cyc(8);
        `CHK("cs_held", 9'h05a, {CS_N_O[0], far_rx})
        CS_CFG_I[0].cs_hold_after_transfer <= 1'b0;
        xfer(2'h0, 8'h77);
        wait_for(1);
        $display("done held select");
        far_lag = 8;
        put(8'h81, 1'b0);
        put(8'h42, 1'b0);
        cmd(DIS);
        `CHK("tx_kept", 2'b00, {ENABLED_O, TX_EMPTY_O})
        put(8'he7, 1'b0);
        wait_for(1);
        cyc(4);
        cmd(RD);
        cmd(EN);
        wait_for(0);
        cmd(RD);
        `CHK("far_rx", 8'h42, far_rx)
        $display("done disable with queued data");
        MODE_I.mode_fault_disable <= 1'b0;
        NSS_I <= 1'b0;
        cyc(6);
        `CHK("fault", 6'h2f, {MODE_FAULT_O, ENABLED_O, CS_N_O})
        NSS_I <= 1'b1;
        cmd(CLR);
        `CHK("fault_clr", 1'b0, MODE_FAULT_O)
        MODE_I.mode_fault_disable <= 1'b1;
        cmd(EN);
        for (int k = 0; k < 2; k++) begin
            CS_CFG_I[0] <= '{k ? 8'h02 : 8'h01, 1, 0, 0};
            CS_CFG_I[1] <= '{8'h01, 1, 0, 0};
            xfer(2'h0, 8'h96);
            falls = 0;
            xfer(2'h1, 8'h69);
            `CHK("sck_falls", k + 8, falls)
        end
        $display("done divider mix");
        cmd(SWR);
        MODE_I <= '{1'b0, 1'b1, 2'h0};
        CS_CFG_I[0] <= '{8'h04, 0, 1, 0};
        cmd(EN);
        cyc(1);
        `CHK("rx_glitch", 1'b1, RX_READY_O)
        cmd(DIS);
        `CHK("slave_on", 1'b1, ENABLED_O)
        CS_CFG_I[0].clock_polarity <= 1'b1;
        cyc(2);
        CS_CFG_I[0].clock_polarity <= 1'b0;
        cyc(2);
        cmd(RD);
        `CHK("rx_ready", 1'b0, RX_READY_O)
        put(8'h6d, 1'b0);
        NSS_I <= 1'b0;
        for (int b = 7; b >= 0; b--) begin
            MOSI_I <= SLV[b];
            cyc(8);
            // slave output bit settles long before the leading edge
            miso_got = {miso_got[6:0], MISO_O};
            SCK_I <= 1'b1;
            cyc(8);
            SCK_I <= 1'b0;
        end
        cyc(8);
        `CHK("slave_tx", 9'h16d, {MISO_OE_O, miso_got})
        NSS_I <= 1'b1;
        MOSI_I <= ~MOSI_I;
        wait_for(0);
        `CHK("slave_rx", SLV, RX_DATA_O)
        cmd(RD);
        cmd(SWR);
        `CHK("stopped", 1'b0, ENABLED_O)
        $display("done slave");
        final_report();
    end
endmodule // testbench
`default_nettype wire
